// File: rac_pkg.sv
// package for the right adc input mix control block
// assumes a single core clock and a register port inside the same domain
package rac_pkg;

	// ----------------------------------------
	// register offsets
	// ----------------------------------------
	localparam logic [6:0] OFS_LINE_ONE = 7'h16; // right_line_one_to_right_adc_ctrl
	localparam logic [6:0] OFS_LINE_TWO = 7'h17; // right_line_two_to_right_adc_ctrl

	// ----------------------------------------
	// field positions
	// ----------------------------------------
	localparam int RESV_BIT = 7;
	localparam int LVL_MSB = 6;
	localparam int LVL_LSB = 3;
	localparam int PWR_BIT = 2;
	localparam int BIAS_BIT = 2;
	localparam int SS_MSB = 1;
	localparam int SS_LSB = 0;

	// ----------------------------------------
	// reset values and codes
	// ----------------------------------------
	localparam logic RST_RESV = 1'h0;
	localparam logic [3:0] RST_LVL = 4'hf;
	localparam logic RST_PWR = 1'h0;
	localparam logic [1:0] RST_SS = 2'h0;
	localparam logic RST_BIAS = 1'h0;
	localparam logic [1:0] RST_RESV_LOW = 2'h0;
	localparam logic [3:0] LVL_LAST_GAIN = 4'h8; // -12 db, 1.5 db per step
	localparam logic [3:0] LVL_OFF = 4'hf;
	localparam logic [1:0] SS_EVERY = 2'h0;
	localparam logic [1:0] SS_EVERY_TWO = 2'h1;

	// ----------------------------------------
	// carriers
	// ----------------------------------------
	typedef struct packed {
		logic en;
		logic [6:0] addr;
		logic [7:0] data;
	} rac_wr_t;

	typedef struct packed {
		logic connect;
		logic [3:0] atten;
	} rac_mix_t;

endpackage : rac_pkg

// File: rac_level_dec.sv
// level code decoder for one line input of the mixer
// assumes code comes from a register in the same clock domain
`timescale 1ns/100ps
module rac_level_dec (
	input wire logic [3:0] code, // input level code
	output rac_pkg::rac_mix_t mix // decoded connect and attenuation
);

	// gain codes connect, off and reserved codes leave the input open
	always_comb begin
		mix.connect = (code <= rac_pkg::LVL_LAST_GAIN);
		mix.atten = mix.connect ? code : 4'h0;
	end

endmodule : rac_level_dec

// File: rac_right_adc_mix.sv
// right adc input mix control: two config registers, mixer steering, pga soft-step
// assumes fs_tick and pga_target come from logic on core_clk
`timescale 1ns/100ps
// Behaviour
// - level codes 0000 to 1000 give mixer gain 0 db down to -12 db in 1.5 db steps.
// - a gain code connects its line input to the right adc pga mixer.
// - code 1111 disconnects the input and both level fields reset to 1111.
// - bit 2 of the first register powers up the right adc channel and resets to 0.
// - soft-step code 00 steps once per sample, 01 once per two, 10 and 11 disable it.
// - bit 2 of the second register weakly biases unselected inputs and resets to 0.
// - bits 1 and 0 of the second register read 00 and the host writes only zeros.
module rac_right_adc_mix #(
	parameter int PGA_W = 7 // width of the pga gain code
) (
	input wire logic core_clk, // core clock, 25 mhz
	input wire logic arst_n, // async reset, active low
	input rac_pkg::rac_wr_t wr, // register write request
	input wire logic rd_en, // register read strobe
	input wire logic [6:0] rd_addr, // register read address
	output logic [7:0] rd_data, // read data, one cycle after rd_en
	input wire logic fs_tick, // one pulse per sample period
	input wire logic [PGA_W-1:0] pga_target, // programmed pga gain
	output rac_pkg::rac_mix_t line_one_mix, // right_line_input_one mixer control
	output rac_pkg::rac_mix_t line_two_mix, // right_line_input_two mixer control
	output logic adc_power_up, // right adc channel powered
	output logic weak_bias_en, // weak common-mode bias of unselected inputs
	output logic [PGA_W-1:0] pga_gain // applied pga gain
);

	// ----------------------------------------
	// elaboration checks
	// ----------------------------------------
	if (PGA_W < 1 || PGA_W > 16) begin : g_chk
		$error("PGA_W out of range");
	end

	// ----------------------------------------
	// register file
	// ----------------------------------------
	logic [7:0] reg_one_r, reg_one_nxt;
	logic [7:0] reg_two_r, reg_two_nxt;
	logic [7:0] rd_data_nxt;

	// writes store fields, reserved low bits of second register stay zero
	always_comb begin
		reg_one_nxt = reg_one_r;
		reg_two_nxt = reg_two_r;
		if (wr.en && wr.addr == rac_pkg::OFS_LINE_ONE) begin
			reg_one_nxt = wr.data;
		end
		if (wr.en && wr.addr == rac_pkg::OFS_LINE_TWO) begin
			reg_two_nxt = {wr.data[7:2], rac_pkg::RST_RESV_LOW};
		end
		rd_data_nxt = rd_data;
		if (rd_en) begin
			case (rd_addr)
				rac_pkg::OFS_LINE_ONE: rd_data_nxt = reg_one_r;
				rac_pkg::OFS_LINE_TWO: rd_data_nxt = {reg_two_r[7:2], 2'h0};
				default: rd_data_nxt = 8'h00;
			endcase
		end
	end

	// register storage with documented reset values
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			reg_one_r <= {rac_pkg::RST_RESV, rac_pkg::RST_LVL, rac_pkg::RST_PWR,
				rac_pkg::RST_SS};
			reg_two_r <= {rac_pkg::RST_RESV, rac_pkg::RST_LVL, rac_pkg::RST_BIAS,
				rac_pkg::RST_RESV_LOW};
			rd_data <= 8'h00;
		end else begin
			reg_one_r <= reg_one_nxt;
			reg_two_r <= reg_two_nxt;
			rd_data <= rd_data_nxt;
		end
	end

	// ----------------------------------------
	// mixer steering and static controls
	// ----------------------------------------
	rac_pkg::rac_mix_t one_dec, two_dec;
	wire logic [1:0] ss_code = reg_one_r[rac_pkg::SS_MSB:rac_pkg::SS_LSB];

	rac_level_dec u_dec_one (
		.code(reg_one_r[rac_pkg::LVL_MSB:rac_pkg::LVL_LSB]),
		.mix(one_dec)
	);

	rac_level_dec u_dec_two (
		.code(reg_two_r[rac_pkg::LVL_MSB:rac_pkg::LVL_LSB]),
		.mix(two_dec)
	);

	// ----------------------------------------
	// pga soft-step
	// ----------------------------------------
	logic [PGA_W-1:0] gain_nxt;
	logic phase_r, phase_nxt;

	// step one code per interval, or follow target at once when disabled
	always_comb begin
		gain_nxt = pga_gain;
		phase_nxt = phase_r;
		if (ss_code[1]) begin
			gain_nxt = pga_target;
			phase_nxt = 1'b0;
		end else if (fs_tick) begin
			if (ss_code == rac_pkg::SS_EVERY || phase_r) begin
				if (pga_gain < pga_target) begin
					gain_nxt = pga_gain + PGA_W'(1);
				end else if (pga_gain > pga_target) begin
					gain_nxt = pga_gain - PGA_W'(1);
				end
			end
			phase_nxt = (ss_code == rac_pkg::SS_EVERY_TWO) ? ~phase_r : 1'b0;
		end
	end

	// output registers
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			line_one_mix <= '0;
			line_two_mix <= '0;
			adc_power_up <= 1'b0;
			weak_bias_en <= 1'b0;
			pga_gain <= '0;
			phase_r <= 1'b0;
		end else begin
			line_one_mix <= one_dec;
			line_two_mix <= two_dec;
			adc_power_up <= reg_one_r[rac_pkg::PWR_BIT];
			weak_bias_en <= reg_two_r[rac_pkg::BIAS_BIT];
			pga_gain <= gain_nxt;
			phase_r <= phase_nxt;
		end
	end

	// ----------------------------------------
	// assertions
	// ----------------------------------------
	sequence s_step_due;
		!ss_code[1] && fs_tick && (ss_code == rac_pkg::SS_EVERY || phase_r);
	endsequence

	property p_dec_one;
		@(posedge core_clk) disable iff (!arst_n)
		reg_one_r[rac_pkg::LVL_MSB:rac_pkg::LVL_LSB] <= rac_pkg::LVL_LAST_GAIN |=>
			line_one_mix.connect &&
			line_one_mix.atten == $past(reg_one_r[rac_pkg::LVL_MSB:rac_pkg::LVL_LSB]);
	endproperty
	a_dec_one: assert property (p_dec_one) else $error("line one gain decode wrong");

	property p_dec_two;
		@(posedge core_clk) disable iff (!arst_n)
		reg_two_r[rac_pkg::LVL_MSB:rac_pkg::LVL_LSB] <= rac_pkg::LVL_LAST_GAIN |=>
			line_two_mix.connect &&
			line_two_mix.atten == $past(reg_two_r[rac_pkg::LVL_MSB:rac_pkg::LVL_LSB]);
	endproperty
	a_dec_two: assert property (p_dec_two) else $error("line two not connected");

	property p_off_one;
		@(posedge core_clk) disable iff (!arst_n)
		reg_one_r[rac_pkg::LVL_MSB:rac_pkg::LVL_LSB] == rac_pkg::LVL_OFF |=>
			!line_one_mix.connect && line_one_mix.atten == 4'h0;
	endproperty
	a_off_one: assert property (p_off_one) else $error("line one not disconnected");

	property p_off_two;
		@(posedge core_clk) disable iff (!arst_n)
		reg_two_r[rac_pkg::LVL_MSB:rac_pkg::LVL_LSB] == rac_pkg::LVL_OFF |=>
			!line_two_mix.connect && line_two_mix.atten == 4'h0;
	endproperty
	a_off_two: assert property (p_off_two) else $error("line two not disconnected");

	property p_pwr;
		@(posedge core_clk) disable iff (!arst_n)
		$changed(reg_one_r[rac_pkg::PWR_BIT]) |=>
			adc_power_up == $past(reg_one_r[rac_pkg::PWR_BIT]) ##1
			adc_power_up == $past(reg_one_r[rac_pkg::PWR_BIT]);
	endproperty
	a_pwr: assert property (p_pwr) else $error("power control not followed");

	property p_bias;
		@(posedge core_clk) disable iff (!arst_n)
		1'b1 |=> weak_bias_en == $past(reg_two_r[rac_pkg::BIAS_BIT]);
	endproperty
	a_bias: assert property (p_bias) else $error("weak bias not followed");

	property p_resv;
		@(posedge core_clk) disable iff (!arst_n)
		rd_en && rd_addr == rac_pkg::OFS_LINE_TWO |=> rd_data[1:0] == rac_pkg::RST_RESV_LOW &&
			rd_data[7:2] == $past(reg_two_r[7:2]);
	endproperty
	a_resv: assert property (p_resv) else $error("reserved bits not zero");

	property p_ss_off;
		@(posedge core_clk) disable iff (!arst_n)
		ss_code[1] |=> pga_gain == $past(pga_target);
	endproperty
	a_ss_off: assert property (p_ss_off) else $error("disabled soft-step did not jump");

	property p_ss_hold;
		@(posedge core_clk) disable iff (!arst_n)
		!ss_code[1] && !fs_tick |=> $stable(pga_gain);
	endproperty
	a_ss_hold: assert property (p_ss_hold) else $error("gain moved between steps");

	property p_ss_up;
		@(posedge core_clk) disable iff (!arst_n)
		s_step_due and (pga_gain < pga_target) |=> pga_gain == PGA_W'($past(pga_gain) + PGA_W'(1));
	endproperty
	a_ss_up: assert property (p_ss_up) else $error("gain did not step up by one");

	property p_ss_down;
		@(posedge core_clk) disable iff (!arst_n)
		s_step_due and (pga_gain > pga_target) |=> pga_gain == PGA_W'($past(pga_gain) - PGA_W'(1));
	endproperty
	a_ss_down: assert property (p_ss_down) else $error("gain did not step down by one");

	property p_ss_two;
		@(posedge core_clk) disable iff (!arst_n)
		ss_code == rac_pkg::SS_EVERY_TWO && fs_tick && !phase_r |=> $stable(pga_gain);
	endproperty
	a_ss_two: assert property (p_ss_two) else $error("half-rate step taken early");

endmodule : rac_right_adc_mix

// File: rac_host_model.sv
// host model: drives register port and sample tick of the mix block
// assumes one core clock shared with the block
`timescale 1ns/100ps
module rac_host_model (
	input wire logic core_clk, // core clock
	output rac_pkg::rac_wr_t wr, // write request
	output logic rd_en, // read strobe
	output logic [6:0] rd_addr, // read address
	input wire logic [7:0] rd_data, // read data
	output logic fs_tick // sample pulse
);
	// ------------------------------
	// bus tasks
	// ------------------------------
	initial begin
		wr = '0;
		rd_en = 1'h0;
		rd_addr = 7'h00;
		fs_tick = 1'h0;
	end
	// write a level, bit 2 and low field; low field of second register kept zero
	task set_reg(input logic [6:0] a, input logic [3:0] lv, input logic b2, input logic [1:0] ss);
		@(posedge core_clk);
		wr <= '{1'h1, a, {1'h0, lv, b2, (a == rac_pkg::OFS_LINE_TWO) ? 2'h0 : ss}};
		@(posedge core_clk);
		wr.en <= 1'h0;
	endtask : set_reg
	// read one register, data taken after the request edge
	task rd_reg(input logic [6:0] a, output logic [7:0] d);
		@(posedge core_clk);
		rd_en <= 1'h1;
		rd_addr <= a;
		@(posedge core_clk);
		rd_en <= 1'h0;
		#1 d = rd_data;
	endtask : rd_reg
	// one sample period pulse
	task tick;
		@(posedge core_clk);
		fs_tick <= 1'h1;
		@(posedge core_clk);
		fs_tick <= 1'h0;
	endtask : tick
endmodule : rac_host_model

// File: tb_top.sv
// testbench of the right adc input mix control block
// assumes the host model drives the register port
`timescale 1ns/100ps
module tb_top;
	logic core_clk;
	logic arst_n;
	logic [6:0] tgt;
	logic [7:0] rd_data;
	logic [7:0] d;
	rac_pkg::rac_wr_t wr;
	logic rd_en;
	logic fs_tick;
	logic [6:0] rd_addr;
	logic [6:0] pga_gain;
	logic adc_power_up;
	logic weak_bias_en;
	rac_pkg::rac_mix_t line_one_mix;
	rac_pkg::rac_mix_t line_two_mix;
	int err_count = 0;
	int n_tests = 0;
	int cycles = 0;
	rac_right_adc_mix u_rac_right_adc_mix (.core_clk(core_clk), .arst_n(arst_n), .wr(wr),
		.rd_en(rd_en), .rd_addr(rd_addr), .rd_data(rd_data), .fs_tick(fs_tick),
		.pga_target(tgt), .line_one_mix(line_one_mix), .line_two_mix(line_two_mix),
		.adc_power_up(adc_power_up), .weak_bias_en(weak_bias_en), .pga_gain(pga_gain));
	rac_host_model u_rac_host_model (.core_clk(core_clk), .wr(wr), .rd_en(rd_en),
		.rd_addr(rd_addr), .rd_data(rd_data), .fs_tick(fs_tick));
	// ------------------------------
	// helpers
	// ------------------------------
	task chk(input string nm, input logic [15:0] g, input logic [15:0] e);
		n_tests++;
		if (g !== e) begin
			err_count++;
			$display("[ERR] %s exp %h got %h", nm, e, g);
		end
	endtask : chk
	task wt(input int n);
		repeat (n) @(posedge core_clk);
		#1;
	endtask : wt
	task results;
		$display("errors %0d checks %0d", err_count, n_tests);
		if (err_count == 0 && n_tests > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask : results
	// ------------------------------
	// scenarios
	// ------------------------------
	task t_reset;
		wt(1);
		chk("mix1", 16'(line_one_mix), 16'h0000);
		chk("pwr", 16'(adc_power_up), 16'h0000);
		chk("bias", 16'(weak_bias_en), 16'h0000);
		u_rac_host_model.rd_reg(rac_pkg::OFS_LINE_ONE, d);
		chk("reg1", 16'(d), 16'h0078);
		u_rac_host_model.rd_reg(rac_pkg::OFS_LINE_TWO, d);
		chk("reg2", 16'(d), 16'h0078);
	endtask : t_reset
	task t_levels;
		logic [3:0] lv;
		logic [4:0] em;
		for (int c = 0; c <= 10; c++) begin
			lv = (c == 9) ? 4'hf : 4'(c % 9);
			em = (c == 9) ? 5'h00 : {1'h1, lv};
			u_rac_host_model.set_reg(rac_pkg::OFS_LINE_ONE, lv, c != 10, 2'h2);
			u_rac_host_model.set_reg(rac_pkg::OFS_LINE_TWO, lv, c != 10, 2'h0);
			wt(1);
			chk("mix1", 16'(line_one_mix), 16'(em));
			chk("mix2", 16'(line_two_mix), 16'(em));
			chk("pwr", 16'(adc_power_up), 16'(c != 10));
			chk("bias", 16'(weak_bias_en), 16'(c != 10));
			u_rac_host_model.rd_reg(rac_pkg::OFS_LINE_TWO, d);
			chk("reg2", 16'(d), 16'({1'h0, lv, c != 10, 2'h0}));
			u_rac_host_model.rd_reg(rac_pkg::OFS_LINE_ONE, d);
			chk("reg1", 16'(d), 16'({1'h0, lv, c != 10, 2'h2}));
		end
		u_rac_host_model.rd_reg(7'h18, d);
		chk("unmapped", 16'(d), 16'h0000);
	endtask : t_levels
	task t_soft;
		logic [6:0] e;
		@(posedge core_clk) tgt <= 7'h05;
		u_rac_host_model.set_reg(rac_pkg::OFS_LINE_ONE, 4'h0, 1'h1, 2'h2);
		wt(2);
		chk("gain_off", 16'(pga_gain), 16'h0005);
		u_rac_host_model.set_reg(rac_pkg::OFS_LINE_ONE, 4'h0, 1'h1, 2'h1);
		@(posedge core_clk) tgt <= 7'h03;
		e = 7'h05;
		for (int i = 0; i < 4; i++) begin
			u_rac_host_model.tick();
			wt(1);
			if (i % 2 == 1) e = e - 7'h01;
			chk("gain_two", 16'(pga_gain), 16'(e));
		end
		u_rac_host_model.set_reg(rac_pkg::OFS_LINE_ONE, 4'h0, 1'h1, 2'h0);
		@(posedge core_clk) tgt <= 7'h01;
		for (int i = 0; i < 3; i++) begin
			u_rac_host_model.tick();
			wt(1);
			if (e > 7'h01) e = e - 7'h01;
			chk("gain_one", 16'(pga_gain), 16'(e));
		end
		// upward steps, one per tick
		@(posedge core_clk) tgt <= 7'h03;
		for (int i = 0; i < 3; i++) begin
			u_rac_host_model.tick();
			wt(1);
			if (e < 7'h03) e = e + 7'h01;
			chk("gain_up", 16'(pga_gain), 16'(e));
		end
		// code 11 also disables stepping
		u_rac_host_model.set_reg(rac_pkg::OFS_LINE_ONE, 4'h0, 1'h1, 2'h3);
		@(posedge core_clk) tgt <= 7'h06;
		wt(2);
		chk("gain_off3", 16'(pga_gain), 16'h0006);
	endtask : t_soft
	// reset in mid-run restores register and output values
	task t_rerst;
		u_rac_host_model.set_reg(rac_pkg::OFS_LINE_TWO, 4'h2, 1'h1, 2'h0);
		wt(2);
		chk("bias_set", 16'(weak_bias_en), 16'h0001);
		arst_n <= 1'h0;
		wt(2);
		chk("mix2_rst", 16'(line_two_mix), 16'h0000);
		chk("gain_in_rst", 16'(pga_gain), 16'h0000);
		arst_n <= 1'h1;
		wt(1);
		chk("pwr_rst", 16'(adc_power_up), 16'h0000);
		chk("bias_rst", 16'(weak_bias_en), 16'h0000);
		u_rac_host_model.rd_reg(rac_pkg::OFS_LINE_ONE, d);
		chk("reg1_rst", 16'(d), 16'h0078);
		u_rac_host_model.rd_reg(rac_pkg::OFS_LINE_TWO, d);
		chk("reg2_rst", 16'(d), 16'h0078);
	endtask : t_rerst
	// ------------------------------
	// clock, reset, sequence, timeout
	// ------------------------------
	initial begin
		core_clk = 1'h0;
		forever #20 core_clk = ~core_clk;
	end
	always @(posedge core_clk) begin
		cycles <= cycles + 1;
		if (cycles == 3000) begin
			err_count++;
			results();
		end
	end
	initial begin
		arst_n = 1'h0;
		tgt = 7'h00;
		repeat (8) @(posedge core_clk);
		arst_n <= 1'h1;
		t_reset();
		chk("gain_rst", 16'(pga_gain), 16'h0000);
		t_levels();
		t_soft();
		t_rerst();
		results();
	end
endmodule : tb_top
